// file: logic/asb_core.sv
// execution datapath: add, add with carry, and, arithmetic shifts, bit clear, branches
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_core
   import asb_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic issue_valid_i,
   output logic ready_o,
   input wire asb_op_t op_i,
   input wire asb_form_t form_i,
   input wire asb_width_t width_i,
   input wire logic [`ASB_RF_AW-1:0] base_idx_i,
   input wire logic [`ASB_RF_AW-1:0] src_idx_i,
   input wire logic [`ASB_RF_AW-1:0] dst_idx_i,
   input wire logic [`ASB_LIT_W-1:0] lit_i,
   input wire logic [`ASB_BIT_W-1:0] bit_idx_i,
   input wire asb_cond_t cond_i,
   input wire logic [`ASB_PC_W-1:0] target_i,
   input wire logic [`ASB_FILE_AW-1:0] file_addr_i,
   input wire logic [`ASB_DW-1:0] file_data_i,
   output logic file_wr_o,
   output logic [1:0] file_be_o,
   output logic [`ASB_FILE_AW-1:0] file_addr_o,
   output logic [`ASB_DW-1:0] file_wdata_o,
   output logic retire_o,
   output logic illegal_o,
   output logic branch_taken_o,
   output logic [`ASB_PC_W-1:0] branch_target_o,
   output logic arith_out_flag_o,
   output logic half_arith_flag_o,
   output logic msb_set_flag_o,
   output logic signed_wrap_flag_o,
   output logic result_is_null_flag_o
);
   // execute-stage copies of the accepted instruction
   logic ex_valid_q;
   logic ex_bad_q;
   asb_op_t ex_op_q;
   asb_form_t ex_form_q;
   asb_width_t ex_width_q;
   logic [`ASB_RF_AW-1:0] ex_src_q;
   logic [`ASB_RF_AW-1:0] ex_dst_q;
   logic [`ASB_LIT_W-1:0] ex_lit_q;
   logic [`ASB_BIT_W-1:0] ex_bit_q;
   asb_cond_t ex_cond_q;
   logic [`ASB_PC_W-1:0] ex_target_q;
   logic [`ASB_FILE_AW-1:0] ex_faddr_q;
   logic [`ASB_DW-1:0] ex_fdata_q;
   logic c_q, hc_q, n_q, wrap_q, z_q;
   logic [`ASB_RD_PORTS-1:0][`ASB_RF_AW-1:0] rd_addr;
   logic [`ASB_RD_PORTS-1:0][`ASB_DW-1:0] rd_data;
   logic take;

   // issue-side checks: operand form legal for the operation, width, literal range
   wire logic accept = issue_valid_i && ready_o;
   wire logic is_arith = (op_i == sum_op) || (op_i == sum_carry_op) || (op_i == and_op);
   wire logic form_ok = is_arith ? (form_i != fm_reg_one) :
                        (op_i == shift_right_signed_op) ?
                           (form_i inside {fm_file_f, fm_file_accum, fm_reg_one}) :
                        (op_i == barrel_shift_op) ? (form_i inside {fm_reg_reg, fm_reg_short}) :
                        (op_i == clear_bit_op) ? (form_i inside {fm_file_f, fm_reg_one}) :
                        1'b1;
   wire logic lit_bad = (form_i == fm_lit_wide) && (width_i == wd_byte) &&
                        (lit_i > `ASB_LIT_BYTE_MAX);
   // double-word needs register pairs, refused for every operation except the branch
   wire logic width_bad = (op_i != jump_cond_op) && (width_i == wd_dword);
   wire logic issue_bad = !form_ok || lit_bad || width_bad;

   // read ports: base, source (or the literal form's destination), and W0
   assign rd_addr[`ASB_PORT_A] = base_idx_i;
   assign rd_addr[`ASB_PORT_B] = (form_i == fm_lit_wide) ? dst_idx_i : src_idx_i;
   assign rd_addr[`ASB_PORT_W0] = `ASB_ACCUM_IDX;

   wire logic [`ASB_DW-1:0] ra = rd_data[`ASB_PORT_A];
   wire logic [`ASB_DW-1:0] rb = rd_data[`ASB_PORT_B];
   wire logic [`ASB_DW-1:0] rw0 = rd_data[`ASB_PORT_W0];

   // operand selection per form
   wire logic ex_go = ex_valid_q && !ex_bad_q;
   wire logic byte_m = (ex_width_q == wd_byte);
   wire logic file_form = (ex_form_q == fm_file_f) || (ex_form_q == fm_file_accum);
   wire logic [`ASB_DW-1:0] lit_ext = {{(`ASB_DW-`ASB_LIT_W){1'b0}}, ex_lit_q};
   wire logic [`ASB_DW-1:0] short_ext = {{(`ASB_DW-`ASB_SHAMT_W){1'b0}},
                                         ex_lit_q[`ASB_SHAMT_W-1:0]};
   wire logic [`ASB_DW-1:0] op_a = file_form ? ex_fdata_q :
                                   (ex_form_q == fm_lit_wide) ? rb : ra;
   wire logic [`ASB_DW-1:0] op_b = file_form ? rw0 :
                                   (ex_form_q == fm_lit_wide) ? lit_ext :
                                   (ex_form_q == fm_reg_short) ? short_ext : rb;
   wire logic [`ASB_DW-1:0] one_opd = file_form ? ex_fdata_q : rb;
   wire logic cin = (ex_op_q == sum_carry_op) && c_q;

   // adder with carries out of the nibble, byte and word
   wire logic [`ASB_NIB:0] nib_sum = {1'b0, op_a[`ASB_NIB-1:0]} +
                                     {1'b0, op_b[`ASB_NIB-1:0]} + {{`ASB_NIB{1'b0}}, cin};
   wire logic [`ASB_BW:0] low_sum = {1'b0, op_a[`ASB_BW-1:0]} +
                                    {1'b0, op_b[`ASB_BW-1:0]} + {{`ASB_BW{1'b0}}, cin};
   wire logic [`ASB_DW:0] word_sum = {1'b0, op_a} + {1'b0, op_b} +
                                     {{`ASB_DW{1'b0}}, cin};
   wire logic add_c = byte_m ? low_sum[`ASB_BW] : word_sum[`ASB_DW];
   wire logic add_hc = byte_m ? nib_sum[`ASB_NIB] : low_sum[`ASB_BW];

   // sign-extend the working width so the shifts replicate the right bit
   wire logic [`ASB_DW-1:0] one_sx = byte_m ?
      {{`ASB_BW{one_opd[`ASB_BW-1]}}, one_opd[`ASB_BW-1:0]} : one_opd;
   wire logic [`ASB_DW-1:0] base_sx = byte_m ?
      {{`ASB_BW{ra[`ASB_BW-1]}}, ra[`ASB_BW-1:0]} : ra;
   wire logic [`ASB_SHAMT_W-1:0] shamt = (ex_form_q == fm_reg_reg) ?
      rb[`ASB_SHAMT_W-1:0] : ex_lit_q[`ASB_SHAMT_W-1:0];
   wire logic [`ASB_DW-1:0] shr1_res = {one_sx[`ASB_DW-1], one_sx[`ASB_DW-1:1]};
   wire logic [`ASB_DW-1:0] barrel_res = $signed(base_sx) >>> shamt;
   wire logic [`ASB_DW-1:0] clr_res = one_opd & ~(`ASB_WORD_ONE << ex_bit_q);

   // result select and width-masked flag sources
   wire logic [`ASB_DW-1:0] res = (ex_op_q == and_op) ? (op_a & op_b) :
                                  (ex_op_q == shift_right_signed_op) ? shr1_res :
                                  (ex_op_q == barrel_shift_op) ? barrel_res :
                                  (ex_op_q == clear_bit_op) ? clr_res :
                                  word_sum[`ASB_DW-1:0];
   wire logic [`ASB_DW-1:0] res_m = byte_m ? {`ASB_BYTE_ZERO, res[`ASB_BW-1:0]} : res;
   wire logic res_zero = (res_m == `ASB_WORD_ZERO);
   wire logic res_msb = byte_m ? res[`ASB_BW-1] : res[`ASB_DW-1];
   wire logic a_msb = byte_m ? op_a[`ASB_BW-1] : op_a[`ASB_DW-1];
   wire logic b_msb = byte_m ? op_b[`ASB_BW-1] : op_b[`ASB_DW-1];
   wire logic add_wrap = (a_msb == b_msb) && (res_msb != a_msb);

   // which flags each operation may touch
   wire logic is_add = (ex_op_q == sum_op) || (ex_op_q == sum_carry_op);
   wire logic upd_nz = ex_go && (ex_op_q != clear_bit_op) && (ex_op_q != jump_cond_op);
   wire logic upd_c_wrap = ex_go && (is_add || (ex_op_q == shift_right_signed_op));
   wire logic upd_hc = ex_go && is_add;
   wire logic c_d = is_add ? add_c : one_opd[0];
   wire logic wrap_d = is_add ? add_wrap : 1'b0;
   // a carry-in chain may only clear the zero flag, so multiword zero holds
   wire logic z_d = (ex_op_q == sum_carry_op) ? (z_q && res_zero) : res_zero;

   // destination: file register, W0, or a working register
   wire logic is_jump = ex_go && (ex_op_q == jump_cond_op);
   wire logic wr_file = ex_go && !is_jump && (ex_form_q == fm_file_f);
   wire logic rf_we = ex_go && !is_jump && (ex_form_q != fm_file_f);
   wire logic [`ASB_RF_AW-1:0] rf_waddr = (ex_form_q == fm_file_accum) ? `ASB_ACCUM_IDX :
      ((ex_op_q == clear_bit_op) ? ex_src_q : ex_dst_q);
   wire logic [1:0] wbe = byte_m ? `ASB_BE_BYTE : `ASB_BE_WORD;

   // file operand forwarding: the store in execute and the one now on the port
   wire logic fwd_ex = wr_file && (ex_faddr_q == file_addr_i);
   wire logic fwd_port = file_wr_o && (file_addr_o == file_addr_i);
   wire logic [`ASB_DW-1:0] fdata_port = fwd_port ?
      asb_merge(file_data_i, file_wdata_o, file_be_o) : file_data_i;
   wire logic [`ASB_DW-1:0] fdata_d = fwd_ex ? asb_merge(fdata_port, res, wbe) : fdata_port;

   // a taken branch holds issue for its second cycle
   wire logic branch_go = is_jump && take;
   assign ready_o = !branch_go;

   asb_regfile u_rf (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .we_i(rf_we),
      .waddr_i(rf_waddr),
      .wbe_i(wbe),
      .wdata_i(res),
      .raddr_i(rd_addr),
      .rdata_o(rd_data)
   );

   asb_cond u_cond (
      .cond_i(ex_cond_q),
      .arith_out_flag_i(c_q),
      .msb_set_flag_i(n_q),
      .signed_wrap_flag_i(wrap_q),
      .result_is_null_flag_i(z_q),
      .take_o(take)
   );

   // capture the accepted instruction into execute
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ex_valid_q <= 1'b0;
         ex_bad_q <= 1'b0;
         ex_op_q <= sum_op;
         ex_form_q <= fm_file_f;
         ex_width_q <= wd_word;
         ex_src_q <= `ASB_ACCUM_IDX;
         ex_dst_q <= `ASB_ACCUM_IDX;
         ex_lit_q <= '0;
         ex_bit_q <= '0;
         ex_cond_q <= cond_always;
         ex_target_q <= '0;
         ex_faddr_q <= '0;
         ex_fdata_q <= `ASB_WORD_ZERO;
      end else begin
         ex_valid_q <= accept;
         if (accept) begin
            ex_bad_q <= issue_bad;
            ex_op_q <= op_i;
            ex_form_q <= form_i;
            ex_width_q <= width_i;
            ex_src_q <= src_idx_i;
            ex_dst_q <= dst_idx_i;
            ex_lit_q <= lit_i;
            ex_bit_q <= bit_idx_i;
            ex_cond_q <= cond_i;
            ex_target_q <= target_i;
            ex_faddr_q <= file_addr_i;
            ex_fdata_q <= fdata_d;
         end
      end
   end

   // status flags, each updated only by the operations that own it
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         c_q <= 1'b0;
         hc_q <= 1'b0;
         n_q <= 1'b0;
         wrap_q <= 1'b0;
         z_q <= 1'b0;
      end else begin
         if (upd_c_wrap) c_q <= c_d;
         if (upd_c_wrap) wrap_q <= wrap_d;
         if (upd_hc) hc_q <= add_hc;
         if (upd_nz) n_q <= res_msb;
         if (upd_nz) z_q <= z_d;
      end
   end

   // registered outputs: file store, retire, refusal, branch redirect
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         file_wr_o <= 1'b0;
         file_be_o <= '0;
         file_addr_o <= '0;
         file_wdata_o <= `ASB_WORD_ZERO;
         retire_o <= 1'b0;
         illegal_o <= 1'b0;
         branch_taken_o <= 1'b0;
         branch_target_o <= '0;
      end else begin
         file_wr_o <= wr_file;
         file_be_o <= wbe;
         file_addr_o <= ex_faddr_q;
         file_wdata_o <= res;
         retire_o <= ex_go;
         illegal_o <= ex_valid_q && ex_bad_q;
         branch_taken_o <= branch_go;
         branch_target_o <= {ex_target_q[`ASB_PC_W-1:1], `ASB_TARGET_LSB};
      end
   end

   assign arith_out_flag_o = c_q;
   assign half_arith_flag_o = hc_q;
   assign msb_set_flag_o = n_q;
   assign signed_wrap_flag_o = wrap_q;
   assign result_is_null_flag_o = z_q;

   // checks on the datapath's own behaviour
   sequence s_issue_ok;
      accept && !issue_bad && (op_i != jump_cond_op);
   endsequence
   sequence s_retired;
      ##2 retire_o;
   endsequence
   property p_one_cycle;
      @(posedge clk_i) disable iff (!reset_n_i) s_issue_ok |-> s_retired;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("op retired late");
   property p_taken_stall;
      @(posedge clk_i) disable iff (!reset_n_i)
         branch_go |-> !ready_o ##1 (branch_taken_o && ready_o);
   endproperty
   a_taken_stall: assert property (p_taken_stall) else $error("taken branch timing");
   property p_untaken;
      @(posedge clk_i) disable iff (!reset_n_i) (is_jump && !take) |-> ready_o ##1 !branch_taken_o;
   endproperty
   a_untaken: assert property (p_untaken) else $error("untaken branch stalled");
   property p_jump_flags;
      @(posedge clk_i) disable iff (!reset_n_i)
         is_jump |=> ($stable(c_q) && $stable(hc_q) && $stable(n_q) &&
                      $stable(wrap_q) && $stable(z_q));
   endproperty
   a_jump_flags: assert property (p_jump_flags) else $error("branch changed flags");
   property p_clr_flags;
      @(posedge clk_i) disable iff (!reset_n_i) (ex_go && ex_op_q == clear_bit_op) |=>
         ($stable(c_q) && $stable(hc_q) && $stable(n_q) && $stable(wrap_q) && $stable(z_q));
   endproperty
   a_clr_flags: assert property (p_clr_flags) else $error("bit clear changed flags");
   property p_sticky_null;
      @(posedge clk_i) disable iff (!reset_n_i)
         (ex_go && ex_op_q == sum_carry_op && !z_q) |=> !z_q;
   endproperty
   a_sticky_null: assert property (p_sticky_null) else $error("carry add set zero flag");
   property p_narrow_flags;
      @(posedge clk_i) disable iff (!reset_n_i)
         (ex_go && (ex_op_q == and_op || ex_op_q == barrel_shift_op)) |=>
         ($stable(c_q) && $stable(hc_q) && $stable(wrap_q) && (z_q == $past(res_zero)));
   endproperty
   a_narrow_flags: assert property (p_narrow_flags) else $error("narrow flags wrong");
   property p_lit_range;
      @(posedge clk_i) disable iff (!reset_n_i)
         (accept && lit_bad) |-> ##2 (illegal_o && !retire_o);
   endproperty
   a_lit_range: assert property (p_lit_range) else $error("byte literal too big");
   property p_accum_dest;
      @(posedge clk_i) disable iff (!reset_n_i)
         (rf_we && ex_form_q == fm_file_accum) |-> (rf_waddr == `ASB_ACCUM_IDX);
   endproperty
   a_accum_dest: assert property (p_accum_dest) else $error("W0 not the target");
   property p_target_even;
      @(posedge clk_i) disable iff (!reset_n_i) branch_taken_o |-> !branch_target_o[0];
   endproperty
   a_target_even: assert property (p_target_even) else $error("odd branch target");
endmodule

// file: common/asb_cfg.svh
// constants for the add, shift, bit-clear and branch execution datapath
`ifndef ASB_CFG_SVH
`define ASB_CFG_SVH
`define ASB_DW 16
`define ASB_BW 8
`define ASB_NIB 4
`define ASB_RF_N 16
`define ASB_RF_AW 4
`define ASB_RD_PORTS 3
`define ASB_PORT_A 0
`define ASB_PORT_B 1
`define ASB_PORT_W0 2
`define ASB_ACCUM_IDX 4'h0
`define ASB_FILE_AW 13
`define ASB_PC_W 23
`define ASB_LIT_W 10
`define ASB_LIT_BYTE_MAX 10'h0FF
`define ASB_SHAMT_W 5
`define ASB_BIT_W 4
`define ASB_BE_WORD 2'h3
`define ASB_BE_BYTE 2'h1
`define ASB_WORD_ZERO 16'h0000
`define ASB_WORD_ONE 16'h0001
`define ASB_BYTE_ZERO 8'h00
`define ASB_TARGET_LSB 1'b0
`endif

// file: common/asb_pkg.sv
// types and helpers shared by the execution datapath modules
`include "asb_cfg.svh"
package asb_pkg;
   typedef enum logic [2:0] {
      sum_op,
      sum_carry_op,
      and_op,
      shift_right_signed_op,
      barrel_shift_op,
      clear_bit_op,
      jump_cond_op
   } asb_op_t;

   // operand forms as the decoder classifies them
   typedef enum logic [2:0] {
      fm_file_f,
      fm_file_accum,
      fm_lit_wide,
      fm_reg_reg,
      fm_reg_short,
      fm_reg_one
   } asb_form_t;

   typedef enum logic [1:0] {
      wd_word,
      wd_byte,
      wd_dword
   } asb_width_t;

   typedef enum logic [4:0] {
      cond_always,
      cond_carry,
      cond_no_carry,
      cond_null,
      cond_not_null,
      cond_neg,
      cond_not_neg,
      cond_wrap,
      cond_no_wrap,
      cond_sgn_ge,
      cond_sgn_gt,
      cond_sgn_lt,
      signed_not_above_cond,
      unsigned_not_below_cond,
      cond_uns_gt,
      cond_uns_lt,
      unsigned_not_above_cond
   } asb_cond_t;

   // overlay new bytes onto an old word under byte enables
   function automatic logic [`ASB_DW-1:0] asb_merge(input logic [`ASB_DW-1:0] old_w,
                                                   input logic [`ASB_DW-1:0] new_w,
                                                   input logic [1:0] be);
      asb_merge = {be[1] ? new_w[`ASB_DW-1:`ASB_BW] : old_w[`ASB_DW-1:`ASB_BW],
                   be[0] ? new_w[`ASB_BW-1:0] : old_w[`ASB_BW-1:0]};
   endfunction
endpackage

// file: logic/asb_regfile.sv
// sixteen-entry working register array, registered reads with write-through
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_regfile
   import asb_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic we_i,
   input wire logic [`ASB_RF_AW-1:0] waddr_i,
   input wire logic [1:0] wbe_i,
   input wire logic [`ASB_DW-1:0] wdata_i,
   input wire logic [`ASB_RD_PORTS-1:0][`ASB_RF_AW-1:0] raddr_i,
   output logic [`ASB_RD_PORTS-1:0][`ASB_DW-1:0] rdata_o
);
   logic [`ASB_DW-1:0] mem_q [`ASB_RF_N];

   // one flop row per entry, byte lanes written independently
   genvar gi;
   generate
      for (gi = 0; gi < `ASB_RF_N; gi++) begin : g_entry
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               mem_q[gi] <= `ASB_WORD_ZERO;
            end else if (we_i && (waddr_i == gi[`ASB_RF_AW-1:0])) begin
               mem_q[gi] <= asb_merge(mem_q[gi], wdata_i, wbe_i);
            end
         end
      end
      // write-through so a back-to-back reader sees the word being written
      for (gi = 0; gi < `ASB_RD_PORTS; gi++) begin : g_port
         wire logic hit = we_i && (waddr_i == raddr_i[gi]);
         wire logic [`ASB_DW-1:0] rd_d = hit ? asb_merge(mem_q[raddr_i[gi]], wdata_i, wbe_i)
                                             : mem_q[raddr_i[gi]];
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               rdata_o[gi] <= `ASB_WORD_ZERO;
            end else begin
               rdata_o[gi] <= rd_d;
            end
         end
      end
   endgenerate
endmodule

// file: logic/asb_cond.sv
// branch condition evaluation from four of the status flags (carry, negative, overflow, zero)
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_cond
   import asb_pkg::*;
(
   input wire asb_cond_t cond_i,
   input wire logic arith_out_flag_i,
   input wire logic msb_set_flag_i,
   input wire logic signed_wrap_flag_i,
   input wire logic result_is_null_flag_i,
   output logic take_o
);
   // signed less-than is negative differing from overflow
   wire logic sgn_lt = msb_set_flag_i ^ signed_wrap_flag_i;
   wire logic c = arith_out_flag_i;
   wire logic z = result_is_null_flag_i;

   // unsigned tests use carry and zero, never the signed pair
   assign take_o = (cond_i == cond_always) ? 1'b1 :
                   (cond_i == cond_carry) ? c :
                   (cond_i == cond_no_carry) ? !c :
                   (cond_i == cond_null) ? z :
                   (cond_i == cond_not_null) ? !z :
                   (cond_i == cond_neg) ? msb_set_flag_i :
                   (cond_i == cond_not_neg) ? !msb_set_flag_i :
                   (cond_i == cond_wrap) ? signed_wrap_flag_i :
                   (cond_i == cond_no_wrap) ? !signed_wrap_flag_i :
                   (cond_i == cond_sgn_ge) ? !sgn_lt :
                   (cond_i == cond_sgn_gt) ? (!sgn_lt && !z) :
                   (cond_i == cond_sgn_lt) ? sgn_lt :
                   (cond_i == signed_not_above_cond) ? (sgn_lt || z) :
                   (cond_i == unsigned_not_below_cond) ? c :
                   (cond_i == cond_uns_gt) ? (c && !z) :
                   (cond_i == cond_uns_lt) ? !c :
                   (cond_i == unsigned_not_above_cond) ? (!c || z) :
                   1'b0;
endmodule

// file: dv/asb_dec_model.sv
// decoder model presenting one instruction at a time to the datapath
`timescale 1ns/1ps
module asb_dec_model
   import asb_pkg::*;
(
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output asb_op_t op_o,
   output asb_form_t form_o,
   output asb_width_t width_o,
   output logic [3:0] base_o,
   output logic [3:0] src_o,
   output logic [3:0] dst_o,
   output logic [9:0] lit_o,
   output logic [3:0] bit_o,
   output asb_cond_t cond_o,
   output logic [22:0] target_o,
   output logic [12:0] faddr_o,
   output logic [15:0] fdata_o
);
   // idle values; file address starts one below the top of the file space
   initial begin
      {valid_o, base_o, src_o, dst_o, lit_o, bit_o, target_o, fdata_o} = '0;
      faddr_o = 13'h1FFE;
      op_o = sum_op;
      form_o = fm_file_f;
      width_o = wd_word;
      cond_o = cond_always;
   end

   // hold the request until ready is seen before the accepting edge
   task automatic issue(asb_op_t o, asb_form_t f, asb_width_t w, logic [3:0] r, logic [9:0] l,
                        asb_cond_t c, logic [15:0] fd);
      int n;
      @(negedge clk_i);
      op_o = o;
      form_o = f;
      width_o = w;
      cond_o = c;
      {base_o, src_o, dst_o} = {r, r, r};
      {lit_o, bit_o, fdata_o} = {l, l[3:0], fd};
      target_o = 23'h1ABCDE;
      faddr_o = faddr_o + 13'h0001; // fresh address, so no store is forwarded
      valid_o = 1'b1;
      for (n = 0; n < 8 && ready_i !== 1'b1; n++) @(negedge clk_i);
      @(posedge clk_i);
      @(negedge clk_i);
      valid_o = 1'b0;
   endtask
endmodule

// file: dv/test_asb_core.sv
// self-checking bench for the execution datapath
`timescale 1ns/1ps
module test_asb_core
   import asb_pkg::*;
;
   logic clk_i, reset_n_i, issue_valid_i, ready_o, file_wr_o, retire_o, illegal_o;
   logic branch_taken_o, arith_out_flag_o, half_arith_flag_o, msb_set_flag_o;
   logic signed_wrap_flag_o, result_is_null_flag_o;
   asb_op_t op_i;
   asb_form_t form_i;
   asb_width_t width_i;
   asb_cond_t cond_i;
   logic [3:0] base_idx_i, src_idx_i, dst_idx_i, bit_idx_i;
   logic [9:0] lit_i;
   logic [22:0] target_i, branch_target_o, tg;
   logic [12:0] file_addr_i, file_addr_o;
   logic [15:0] file_data_i, file_wdata_o, wd;
   logic [1:0] file_be_o, be;
   logic wr, ill, tk, lo;
   logic [4:0] flg;
   int failures = 0;
   int num_checks = 0;
   assign flg = {arith_out_flag_o, half_arith_flag_o, msb_set_flag_o, signed_wrap_flag_o,
                 result_is_null_flag_o};

   asb_core uut(.clk_i, .reset_n_i, .issue_valid_i, .ready_o, .op_i, .form_i, .width_i,
      .base_idx_i, .src_idx_i, .dst_idx_i, .lit_i, .bit_idx_i, .cond_i, .target_i,
      .file_addr_i, .file_data_i, .file_wr_o, .file_be_o, .file_addr_o, .file_wdata_o,
      .retire_o, .illegal_o, .branch_taken_o, .branch_target_o, .arith_out_flag_o,
      .half_arith_flag_o, .msb_set_flag_o, .signed_wrap_flag_o, .result_is_null_flag_o);
   asb_dec_model dec(.clk_i, .ready_i(ready_o), .valid_o(issue_valid_i), .op_o(op_i),
      .form_o(form_i), .width_o(width_i), .base_o(base_idx_i), .src_o(src_idx_i),
      .dst_o(dst_idx_i), .lit_o(lit_i), .bit_o(bit_idx_i), .cond_o(cond_i),
      .target_o(target_i), .faddr_o(file_addr_i), .fdata_o(file_data_i));

   // 25 ns clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic print_verdict;
      if (failures == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk_flags(logic [4:0] e);
      num_checks++;
      if (flg !== e) begin
         failures++;
         $display("MISMATCH %0t flags %b expected %b", $time, flg, e);
      end
   endtask

   task automatic chk_data(logic [39:0] g, logic [39:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t result %h expected %h", $time, g, e);
      end
   endtask

   // issue through W0 and catch the answer two edges later, bounded
   task automatic run(asb_op_t o, asb_form_t f, asb_width_t w, logic [9:0] l, logic [15:0] fd,
                      asb_cond_t c = cond_always);
      int k;
      dec.issue(o, f, w, 4'h0, l, c, fd);
      lo = (ready_o === 1'b0); // a taken branch holds ready low while it executes
      for (k = 0; k < 4; k++) begin
         @(posedge clk_i);
         #1;
         if (ready_o === 1'b0) lo = 1'b1;
         if (retire_o === 1'b1 || illegal_o === 1'b1) break;
      end
      if (k == 4) begin
         failures++;
         $display("MISMATCH %0t no answer", $time);
         print_verdict();
      end
      {wr, be, wd, ill} = {file_wr_o, file_be_o, file_wdata_o, illegal_o};
      {tk, tg} = {branch_taken_o, branch_target_o};
   endtask

   // three compare conditions; taken ones stall a cycle, none touch flags
   task automatic t_br(logic [2:0] e);
      asb_cond_t cs[3] = '{unsigned_not_below_cond, signed_not_above_cond,
                           unsigned_not_above_cond};
      logic [4:0] f0;
      f0 = flg;
      for (int i = 0; i < 3; i++) begin
         run(jump_cond_op, fm_file_f, wd_word, 10'h000, 16'h0000, cs[i]);
         chk_data({ill, tk, lo, tg}, {1'b0, e[2-i], e[2-i], 23'h1ABCDE});
         chk_flags(f0);
      end
   endtask

   task automatic t_add;
      run(sum_op, fm_lit_wide, wd_word, 10'h3FF, 16'h0000);
      chk_flags(5'b00000);
      t_br(3'b001);
      run(sum_op, fm_file_f, wd_word, 10'h000, 16'hFC01);
      chk_data({wr, be, wd}, {1'b1, 2'h3, 16'h0000});
      chk_data(file_addr_o, file_addr_i);
      chk_flags(5'b11001);
   endtask

   task automatic t_carry;
      run(sum_carry_op, fm_file_f, wd_word, 10'h000, 16'hFFFF);
      chk_data(wd, 16'h03FF);
      chk_flags(5'b11000);
      run(sum_carry_op, fm_file_f, wd_word, 10'h000, 16'hFC00);
      chk_flags(5'b11000);
      t_br(3'b100);
   endtask

   // single shift, barrel into W0, then and as the read-back path
   task automatic t_shr;
      run(shift_right_signed_op, fm_file_f, wd_word, 10'h000, 16'h8001);
      chk_data(wd, 16'hC000);
      chk_flags(5'b11100);
      t_br(3'b110);
      run(shift_right_signed_op, fm_file_accum, wd_word, 10'h000, 16'h8001);
      run(barrel_shift_op, fm_reg_short, wd_word, 10'h00D, 16'h0000);
      chk_flags(5'b11100);
      run(and_op, fm_file_f, wd_word, 10'h000, 16'h00FF);
      chk_data(wd, 16'h00FE);
      chk_flags(5'b11000);
   endtask

   task automatic t_clr;
      logic [4:0] f0;
      f0 = flg;
      for (int b = 0; b < 16; b += 15) begin
         run(clear_bit_op, fm_file_f, wd_word, 10'(b), 16'hFFFF);
         chk_data({wr, be, wd}, {1'b1, 2'h3, ~(16'h0001 << b)});
         chk_flags(f0);
      end
      // register form clears bit 15 of W0, then read W0 back through an and
      run(clear_bit_op, fm_reg_one, wd_word, 10'h00F, 16'h0000);
      chk_data({ill, wr}, 2'b00);
      run(and_op, fm_file_f, wd_word, 10'h000, 16'hFFFF);
      chk_data(wd, 16'h7FFE);
      chk_flags(5'b11000);
   endtask

   task automatic t_byte;
      run(sum_op, fm_lit_wide, wd_byte, 10'h100, 16'h0000);
      chk_data(ill, 1'b1);
      run(sum_op, fm_reg_reg, wd_dword, 10'h000, 16'h0000);
      chk_data(ill, 1'b1);
      chk_flags(5'b11000);
      run(sum_op, fm_file_f, wd_byte, 10'h000, 16'h12FF);
      chk_data({ill, be, wd[7:0]}, {1'b0, 2'h1, 8'hFD});
      chk_flags(5'b11100);
   endtask

   // reset, then the scenarios in an order that chains W0 and the flags
   initial begin
      reset_n_i = 1'b0;
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      reset_n_i = 1'b1;
      chk_flags(5'b00000);
      t_add();
      t_carry();
      t_shr();
      t_clr();
      t_byte();
      print_verdict();
   end
endmodule
